// ==== common/sfw_evt_if.sv ====
interface sfw_evt_if;
	logic tog;
	logic [1:0] kind;
	logic [23:0] val;
	logic [7:0] status;

	modport link (output tog, output kind, output val, input status);
	modport core (input tog, input kind, input val, output status);
endinterface

// ==== common/sfw_pkg.sv ====
package sfw_pkg;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OPC_SET_LATCH = 8'h06;
	localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
	localparam logic [7:0] OPC_STAT_READ = 8'h05;
	localparam logic [7:0] OPC_STAT_WRITE = 8'h01;
	localparam logic [7:0] OPC_MEM_WRITE = 8'h02;
	localparam logic [7:0] OPC_SECTOR_WRITE = 8'h42;
	localparam logic [7:0] OPC_SERIAL_WRITE = 8'hc2;

	// ------------------------------------------------------------
	// status register layout
	// ------------------------------------------------------------
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_LATCH_BIT = 1;
	localparam int ST_GUARD0_BIT = 2;
	localparam int ST_GUARD1_BIT = 3;
	localparam int ST_PIN_EN_BIT = 7;
	localparam logic [7:0] ST_FIXED_ONES = 8'h40;
	localparam logic [7:0] ST_RESET = 8'h40;
	localparam logic [2:0] NV_GUARD_RESET = 3'h0;

	// ------------------------------------------------------------
	// address map and protected ranges
	// ------------------------------------------------------------
	localparam int ADDR_W = 17;
	localparam logic [16:0] GUARD_QUARTER_BASE = 17'h18000;
	localparam logic [16:0] GUARD_HALF_BASE = 17'h10000;

	// ------------------------------------------------------------
	// link events and timing
	// ------------------------------------------------------------
	localparam logic [1:0] EV_OPCODE = 2'h0;
	localparam logic [1:0] EV_ADDRESS = 2'h1;
	localparam logic [1:0] EV_STATUS = 2'h2;
	localparam logic [1:0] EV_DATA = 2'h3;
	localparam int END_DELAY_CYCLES = 2;

endpackage

// ==== rtl/sfw_link.sv ====
module sfw_link (
	input logic i_sck,
	input logic i_cs_n,
	input logic i_rst_n,
	input logic i_si,
	output logic o_so,
	output logic o_so_oe,
	sfw_evt_if.link ev
);
	typedef enum logic [5:0] {
		LK_OPCODE = 6'b000001,
		LK_ADDR = 6'b000010,
		LK_MDATA = 6'b000100,
		LK_SDATA = 6'b001000,
		LK_RDSTAT = 6'b010000,
		LK_SKIP = 6'b100000
	} sfw_link_e;

	sfw_link_e state_q;
	sfw_link_e state_d;
	logic [2:0] bit_q;
	logic [6:0] sh_q;
	logic [1:0] nbyte_q;
	logic [23:0] addr_q;
	logic [7:0] st1_q;
	logic [7:0] st2_q;
	logic [7:0] stat_q;
	logic tog_q;
	logic [1:0] kind_q;
	logic [23:0] val_q;
	logic so_q;
	logic oe_q;

	wire byte_done = (bit_q == 3'h7);
	wire [7:0] byte_in = {sh_q, i_si};
	wire addr_last = (state_q == LK_ADDR) && (nbyte_q == 2'h2);
	wire send = byte_done && ((state_q == LK_OPCODE) || addr_last || (state_q == LK_MDATA) || (state_q == LK_SDATA));
	wire [1:0] kind_d = (state_q == LK_OPCODE) ? sfw_pkg::EV_OPCODE :
		(state_q == LK_ADDR) ? sfw_pkg::EV_ADDRESS :
		(state_q == LK_SDATA) ? sfw_pkg::EV_STATUS : sfw_pkg::EV_DATA;
	wire [23:0] val_d = (state_q == LK_ADDR) ? {addr_q[15:0], byte_in} : {16'h0000, byte_in};

	// ------------------------------------------------------------
	// frame sequencing
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		if (byte_done) begin
			case (state_q)
				LK_OPCODE: begin
					case (byte_in)
						sfw_pkg::OPC_MEM_WRITE: state_d = LK_ADDR;
						sfw_pkg::OPC_STAT_WRITE: state_d = LK_SDATA;
						sfw_pkg::OPC_STAT_READ: state_d = LK_RDSTAT;
						default: state_d = LK_SKIP;
					endcase
				end
				LK_ADDR: state_d = addr_last ? LK_MDATA : LK_ADDR;
				LK_SDATA: state_d = LK_SKIP;
				LK_MDATA: state_d = LK_MDATA;
				LK_RDSTAT: state_d = LK_RDSTAT;
				LK_SKIP: state_d = LK_SKIP;
				default: state_d = LK_SKIP;
			endcase
		end
	end

	// frame logic is cleared by chip select itself, the link clock may stop
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			state_q <= LK_OPCODE;
			bit_q <= 3'h0;
			sh_q <= 7'h00;
			nbyte_q <= 2'h0;
			addr_q <= 24'h000000;
		end else begin
			state_q <= state_d;
			bit_q <= bit_q + 3'h1;
			sh_q <= byte_in[6:0];
			if (byte_done && (state_q == LK_ADDR)) begin
				nbyte_q <= nbyte_q + 2'h1;
				addr_q <= {addr_q[15:0], byte_in};
			end
		end
	end

	// ------------------------------------------------------------
	// byte events toward the core clock
	// ------------------------------------------------------------
	// only whole bytes raise an event, a cut byte never reaches the core
	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tog_q <= 1'b0;
			kind_q <= sfw_pkg::EV_OPCODE;
			val_q <= 24'h000000;
		end else if (!i_cs_n && send) begin
			tog_q <= ~tog_q;
			kind_q <= kind_d;
			val_q <= val_d;
		end
	end

	// ------------------------------------------------------------
	// status read out
	// ------------------------------------------------------------
	always_ff @(posedge i_sck) begin
		st1_q <= ev.status;
		st2_q <= st1_q;
		if (byte_done) begin
			stat_q <= st2_q;
		end
	end

	always_ff @(negedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			so_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (state_q == LK_RDSTAT) begin
			oe_q <= 1'b1;
			so_q <= stat_q[~bit_q];
		end
	end

	assign ev.tog = tog_q;
	assign ev.kind = kind_q;
	assign ev.val = val_q;
	assign o_so = so_q;
	assign o_so_oe = oe_q;
endmodule

// ==== rtl/sfw_sync.sv ====
module sfw_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input logic i_clock,
	input logic i_rst_n,
	input logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// a bit only moves once the last two stages agree
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			o_sync <= RST_VAL;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			o_sync <= (s2_q & s3_q) | (o_sync & (s2_q | s3_q));
		end
	end
endmodule

// ==== rtl/sfw_top.sv ====
// Operation
// - latch-clear opcode 04h drops the write latch, blocking further writes.
// - status byte: bit7 pin guard enable, bits3..2 block guard, bit1 latch.
// - bits 4, 5 fixed zero; bit 6 fixed one; none writable.
// - bit 0 reads zero except while waking from a low power mode.
// - status write clears the latch too; latch opcodes and write-type opcodes change it.
// - latch is zero after power up.
// - block guard bits persist across power cycles.
// - guard code selects none, upper quarter, upper half or whole array.
// - array byte written only with latch set and address outside guard.
// - status write refused if latch clear, or pin enable set and pin low.
// - protect pin never blocks array writes, only status writes.
// - after opcode 05h the status byte is shifted out.
// - opcode 01h plus byte updates pin enable and guard bits, clears latch.
// - low 17 bits of three address bytes start the burst.
// - address steps after each data byte, wrapping to zero.
// - bytes arrive most significant bit first; chip select rise ends write.
// - burst reaching guarded address stops stepping, drops remaining bytes.
// - each full byte commits at once; partial bytes are never written.
// - opcode 06h sets the write latch.
// - chip select rise after any write-type opcode clears the latch.
// - first byte is the opcode; unknown opcodes ignore the frame.
module sfw_top (
	input logic i_clock,
	input logic i_rst_n,
	input logic i_sck,
	input logic i_cs_n,
	input logic i_si,
	input logic i_wp_n,
	input logic i_waking,
	input logic [2:0] i_nv_guard,
	output logic o_so,
	output logic o_so_oe,
	output logic o_mem_we,
	output logic [16:0] o_mem_addr,
	output logic [7:0] o_mem_data,
	output logic [2:0] o_nv_guard,
	output logic o_write_latch
);
	sfw_evt_if ev ();

	logic s_cs_n;
	logic s_wp_n;
	logic s_wake;
	logic s_tog;
	logic cs_prev_q;
	logic tog_prev_q;
	logic [sfw_pkg::END_DELAY_CYCLES-1:0] end_pipe_q;
	logic restore_q;
	logic wel_q;
	logic [1:0] bp_q;
	logic pin_guard_enable_q;
	logic clr_op_q;
	logic stop_q;
	logic [16:0] addr_q;
	logic [7:0] status_q;
	logic we_q;
	logic [16:0] wa_q;
	logic [7:0] wd_q;

	// ------------------------------------------------------------
	// link side and crossings
	// ------------------------------------------------------------
	sfw_link u_link (
		.i_sck(i_sck),
		.i_cs_n(i_cs_n),
		.i_rst_n(i_rst_n),
		.i_si(i_si),
		.o_so(o_so),
		.o_so_oe(o_so_oe),
		.ev(ev.link)
	);

	sfw_sync #(.W(4), .RST_VAL(4'b0011)) u_sync (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_async({ev.tog, i_waking, i_wp_n, i_cs_n}),
		.o_sync({s_tog, s_wake, s_wp_n, s_cs_n})
	);

	assign ev.status = status_q;

	// ------------------------------------------------------------
	// event decode
	// ------------------------------------------------------------
	wire ev_hit = (s_tog != tog_prev_q);
	wire [7:0] ev_byte = ev.val[7:0];
	wire frame_fall = cs_prev_q && !s_cs_n;
	wire frame_rise = !cs_prev_q && s_cs_n;
	// the last byte event may land just after the edge, so the close waits
	wire frame_end = end_pipe_q[sfw_pkg::END_DELAY_CYCLES-1];
	wire opc_ev = ev_hit && (ev.kind == sfw_pkg::EV_OPCODE);
	wire addr_ev = ev_hit && (ev.kind == sfw_pkg::EV_ADDRESS);
	wire stat_ev = ev_hit && (ev.kind == sfw_pkg::EV_STATUS);
	wire data_ev = ev_hit && (ev.kind == sfw_pkg::EV_DATA);
	wire set_wel = opc_ev && (ev_byte == sfw_pkg::OPC_SET_LATCH);
	wire is_clr_op = (ev_byte == sfw_pkg::OPC_CLR_LATCH) || (ev_byte == sfw_pkg::OPC_STAT_WRITE) ||
		(ev_byte == sfw_pkg::OPC_MEM_WRITE) || (ev_byte == sfw_pkg::OPC_SECTOR_WRITE) ||
		(ev_byte == sfw_pkg::OPC_SERIAL_WRITE);
	wire clr_wel = frame_end && clr_op_q;

	// ------------------------------------------------------------
	// protection decision
	// ------------------------------------------------------------
	wire in_guard = (bp_q == 2'b11) ||
		((bp_q == 2'b10) && (addr_q >= sfw_pkg::GUARD_HALF_BASE)) ||
		((bp_q == 2'b01) && (addr_q >= sfw_pkg::GUARD_QUARTER_BASE));
	wire mem_ok = wel_q && !in_guard && !stop_q;
	wire mem_wr = data_ev && mem_ok;
	wire stat_ok = wel_q && !(pin_guard_enable_q && !s_wp_n);
	wire stat_wr = stat_ev && stat_ok;
	wire [7:0] status_d = sfw_pkg::ST_FIXED_ONES |
		({7'h00, pin_guard_enable_q} << sfw_pkg::ST_PIN_EN_BIT) |
		({7'h00, bp_q[1]} << sfw_pkg::ST_GUARD1_BIT) |
		({7'h00, bp_q[0]} << sfw_pkg::ST_GUARD0_BIT) |
		({7'h00, wel_q} << sfw_pkg::ST_LATCH_BIT) |
		({7'h00, s_wake} << sfw_pkg::ST_BUSY_BIT);

	// ------------------------------------------------------------
	// frame tracking
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			cs_prev_q <= 1'b1;
			tog_prev_q <= 1'b0;
			end_pipe_q <= '0;
			clr_op_q <= 1'b0;
		end else begin
			cs_prev_q <= s_cs_n;
			tog_prev_q <= s_tog;
			end_pipe_q <= {end_pipe_q[sfw_pkg::END_DELAY_CYCLES-2:0], frame_rise};
			if (opc_ev) begin
				clr_op_q <= is_clr_op;
			end else if (frame_end || frame_fall) begin
				clr_op_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// write latch and status register
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			wel_q <= 1'b0;
			restore_q <= 1'b1;
			status_q <= sfw_pkg::ST_RESET;
		end else begin
			restore_q <= 1'b0;
			status_q <= status_d;
			if (set_wel) begin
				wel_q <= 1'b1;
			end else if (clr_wel) begin
				wel_q <= 1'b0;
			end
		end
	end

	// guard bits are not cleared by reset: restored from storage after release
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			bp_q <= bp_q;
			pin_guard_enable_q <= pin_guard_enable_q;
		end else if (restore_q) begin
			pin_guard_enable_q <= i_nv_guard[2];
			bp_q <= i_nv_guard[1:0];
		end else if (stat_wr) begin
			pin_guard_enable_q <= ev_byte[sfw_pkg::ST_PIN_EN_BIT];
			bp_q <= {ev_byte[sfw_pkg::ST_GUARD1_BIT], ev_byte[sfw_pkg::ST_GUARD0_BIT]};
		end
	end

	// ------------------------------------------------------------
	// burst address and array commit
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			addr_q <= 17'h00000;
			stop_q <= 1'b0;
			we_q <= 1'b0;
			wa_q <= 17'h00000;
			wd_q <= 8'h00;
		end else begin
			we_q <= mem_wr;
			if (frame_fall) begin
				stop_q <= 1'b0;
			end else if (data_ev && !mem_ok) begin
				stop_q <= 1'b1;
			end
			if (addr_ev) begin
				addr_q <= ev.val[16:0];
			end else if (mem_wr) begin
				addr_q <= addr_q + 17'h00001;
			end
			if (mem_wr) begin
				wa_q <= addr_q;
				wd_q <= ev_byte;
			end
		end
	end

	assign o_mem_we = we_q;
	assign o_mem_addr = wa_q;
	assign o_mem_data = wd_q;
	assign o_nv_guard = {pin_guard_enable_q, bp_q};
	assign o_write_latch = wel_q;
endmodule

// ==== sim/sfw_spi_master.sv ====
module sfw_spi_master (
	output logic o_sck,
	output logic o_cs_n,
	output logic o_si,
	input wire logic i_so,
	input wire logic i_so_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// non-blocking, so the first idle select level reaches the design as an edge
	initial begin
		o_sck <= 1'b0;
		o_cs_n <= 1'b1;
		o_si <= 1'b0;
	end

	// one frame, mode 0; clock stands still between frames
	// bytes packed right-aligned, first byte in the highest bits
	task automatic xfer(input logic [63:0] b, input int n, output logic [7:0] rx);
		int i;
		#7 o_cs_n = 1'b0;
		for (i = 0; i < n; i++) begin
			o_si = b[8 * ((n + 7) / 8) - 1 - i];
			#16 o_sck = 1'b1;
			rx = {rx[6:0], i_so_oe ? i_so : 1'bz};
			#16 o_sck = 1'b0;
		end
		#40 o_cs_n = 1'b1;
		// released line must not keep the last bit
		o_si = ~o_si;
		#200;
	endtask
endmodule

// ==== sim/sfw_sva.sv ====
module sfw_sva (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_cs_n,
	input wire logic [2:0] i_nv_guard,
	input wire logic o_so_oe,
	input wire logic o_mem_we,
	input wire logic [16:0] o_mem_addr,
	input wire logic [2:0] o_nv_guard,
	input wire logic o_write_latch
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [16:0] prev_q;
	logic seen_q;
	logic [1:0] up_q;
	wire logic [1:0] bg = o_nv_guard[1:0];
	wire logic hi_half = o_mem_addr >= sfw_pkg::GUARD_HALF_BASE;
	wire logic hi_qtr = o_mem_addr >= sfw_pkg::GUARD_QUARTER_BASE;
	wire logic prot = (bg == 2'h3) || (bg == 2'h2 && hi_half) || (bg == 2'h1 && hi_qtr);

	// --------------------------------
	// helpers
	// --------------------------------
	// first guard load after reset is not a status write, so skip it
	always_ff @(posedge i_clock) begin
		up_q <= i_rst_n ? {up_q[0], 1'b1} : 2'h0;
		seen_q <= i_rst_n && !$fell(i_cs_n) && (seen_q || o_mem_we);
		if (o_mem_we)
			prev_q <= o_mem_addr;
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	// --------------------------------
	// checks
	// --------------------------------
	a_we_one_pulse: assert property (o_mem_we |=> !o_mem_we)
		else $error("commit strobe longer than one cycle");
	a_we_needs_latch: assert property (o_mem_we |-> o_write_latch || $past(o_write_latch))
		else $error("commit without write latch");
	a_we_outside_guard: assert property (o_mem_we |-> !prot)
		else $error("commit inside guarded range");
	a_addr_step: assert property (o_mem_we && seen_q |-> o_mem_addr == prev_q + 17'h1)
		else $error("burst address did not step by one");
	a_latch_fall_idle: assert property ($fell(o_write_latch) |-> i_cs_n)
		else $error("latch cleared inside a frame");
	a_guard_needs_latch: assert property (up_q[1] && $changed(o_nv_guard) |-> o_write_latch || $past(o_write_latch))
		else $error("guard bits changed without latch");
	a_oe_idle: assert property (i_cs_n && $past(i_cs_n, 2) |-> !o_so_oe)
		else $error("serial output driven while deselected");
	a_reset_clean: assert property ($rose(i_rst_n) |-> !o_write_latch && !o_mem_we)
		else $error("latch or commit active out of reset");
	a_guard_restore: assert property ($rose(i_rst_n) |=> o_nv_guard == $past(i_nv_guard))
		else $error("guard bits not restored after reset");

	c_burst: cover property (o_mem_we && seen_q);
	c_latch_clear: cover property ($fell(o_write_latch));
	c_status_out: cover property (o_so_oe);
endmodule

bind sfw_top sfw_sva u_sva (
	.i_clock(i_clock),
	.i_rst_n(i_rst_n),
	.i_cs_n(i_cs_n),
	.i_nv_guard(i_nv_guard),
	.o_so_oe(o_so_oe),
	.o_mem_we(o_mem_we),
	.o_mem_addr(o_mem_addr),
	.o_nv_guard(o_nv_guard),
	.o_write_latch(o_write_latch)
);

// ==== sim/sfw_top_tb_top.sv ====
module sfw_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

	logic i_clock = 1'b0;
	logic i_rst_n = 1'b1;
	logic i_wp_n = 1'b1;
	logic i_waking = 1'b0;
	logic [2:0] i_nv_guard = 3'h1;
	wire logic sck, cs_n, si;
	logic o_so, o_so_oe, o_mem_we, o_write_latch;
	logic [16:0] o_mem_addr;
	logic [7:0] o_mem_data, rx;
	logic [2:0] o_nv_guard;
	logic oe_seen = 1'b0;
	logic [16:0] wa[$];
	logic [7:0] wd[$];
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	int i, g;
	localparam logic [16:0] ST [4] = '{17'h1ffff, 17'h17ffe, 17'h0fffe, 17'h00000};
	localparam int NC [4] = '{3, 2, 2, 0};

	always #10 i_clock = ~i_clock;

	sfw_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
		.i_wp_n(i_wp_n), .i_waking(i_waking), .i_nv_guard(i_nv_guard), .o_so(o_so), .o_so_oe(o_so_oe),
		.o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .o_nv_guard(o_nv_guard),
		.o_write_latch(o_write_latch));
	sfw_spi_master m (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(o_so), .i_so_oe(o_so_oe));

	// --------------------------------
	// monitors
	// --------------------------------
	always @(posedge i_clock) begin
		if (o_mem_we === 1'b1) begin
			wa.push_back(o_mem_addr);
			wd.push_back(o_mem_data);
		end
		if (o_so_oe === 1'b1)
			oe_seen = 1'b1;
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			stop_test();
		end
	end

	// --------------------------------
	// tasks
	// --------------------------------
	task automatic stop_test();
		$display("errors=%0d checks=%0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk_st(input logic [7:0] e);
		m.xfer({8'h05, 8'h00}, 16, rx);
		`CHK(rx, e)
	endtask

	task automatic status_write_cmd(input logic [7:0] d);
		m.xfer({8'h06}, 8, rx);
		m.xfer({8'h01, d}, 16, rx);
	endtask

	// three bytes plus a cut-off fourth; upper address bits are junk
	task automatic mem(input logic [16:0] a);
		logic [23:0] ad;
		ad = {7'h55, a};
		wa.delete();
		wd.delete();
		m.xfer({8'h02, ad[23:16], ad[15:8], ad[7:0], 8'ha0, 8'ha1, 8'ha2, 8'hff}, 61, rx);
	endtask

	// --------------------------------
	// sequence
	// --------------------------------
	initial begin
		// falls from high so the link's asynchronous clear sees an edge
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (8) @(posedge i_clock);
		`CHK(o_nv_guard, 3'h1)
		chk_st(8'h44);
		mem(17'h00010);
		`CHK(wa.size(), 0)
		m.xfer({8'h06}, 8, rx);
		`CHK(o_write_latch, 1'b1)
		chk_st(8'h46);
		m.xfer({8'h04}, 8, rx);
		`CHK(o_write_latch, 1'b0)
		@(posedge i_clock) i_wp_n <= 1'b0;
		for (g = 0; g < 4; g++) begin
			status_write_cmd({4'h0, g[1:0], 2'h2});
			chk_st({4'h4, g[1:0], 2'h0});
			m.xfer({8'h06}, 8, rx);
			mem(ST[g]);
			`CHK(wa.size(), NC[g])
			for (i = 0; i < wa.size(); i++) begin
				`CHK(wa[i], 17'(ST[g] + i))
				`CHK(wd[i], 8'(8'ha0 + i))
			end
			`CHK(o_write_latch, 1'b0)
		end
		status_write_cmd(8'hb1);
		chk_st(8'hc0);
		status_write_cmd(8'h0c);
		chk_st(8'hc0);
		@(posedge i_clock) i_wp_n <= 1'b1;
		status_write_cmd(8'h0c);
		chk_st(8'h4c);
		m.xfer(8'h06, 8, rx);
		m.xfer(8'h42, 8, rx);
		`CHK(o_write_latch, 1'b0)
		m.xfer(8'h06, 8, rx);
		`CHK(o_write_latch, 1'b1)
		m.xfer(8'hc2, 8, rx);
		`CHK(o_write_latch, 1'b0)
		m.xfer({8'h01, 8'h80}, 16, rx);
		chk_st(8'h4c);
		oe_seen = 1'b0;
		m.xfer({8'h9f, 8'hff, 8'hff}, 24, rx);
		`CHK(oe_seen, 1'b0)
		@(posedge i_clock) i_waking <= 1'b1;
		repeat (6) @(posedge i_clock);
		chk_st(8'h4d);
		i_waking <= 1'b0;
		stop_test();
	end
endmodule
